// >>> src/ctf_pkg.sv
package ctf_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CELL_N = 14;
  localparam int TEMP_N = 6;
  localparam int CONV_W = 14;
  localparam int CHAN_W = 3;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CELL_MASK = 4'h0;
  localparam logic [3:0] OFS_FAULT_SETUP = 4'h1;
  localparam logic [3:0] OFS_TEMP_LIMIT = 4'h2;
  localparam logic [3:0] OFS_OT_FAULT = 4'h3;
  localparam logic [3:0] OFS_FAULT_STATUS = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h5;
  localparam logic [3:0] OFS_VALUE_BASE = 4'h8;
  localparam logic [3:0] OFS_VALUE_LAST = 4'hD;

  // ==========================================================
  // field positions
  localparam int STAT_OT_BIT = 0;
  localparam int STAT_REF_BIT = 1;
  localparam int STAT_CELL_BIT = 2;
  localparam int STAT_REFCHK_BIT = 3;
  localparam int CTRL_BIAS_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [13:0] CELL_MASK_RST = 14'h0000;
  localparam logic [5:0] FAULT_SETUP_RST = 6'h00;
  localparam logic [13:0] TEMP_LIMIT_RST = 14'h0000;
  localparam logic [13:0] VALUE_RST = 14'h0000;

  // ==========================================================
  // conversion thresholds: open input above 31/32 of full scale
  localparam logic [13:0] OPEN_THRESH = 14'h3E00;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int REF_DELAY_MS = 20;
  localparam int REF_DELAY_CYC = REF_DELAY_MS * CLK_MHZ * 1000;
  localparam int REF_CNT_W = 23;

  // ==========================================================
  // reference check states
  typedef enum logic [2:0] {
    REF_IDLE  = 3'b001,
    REF_WAIT  = 3'b010,
    REF_CHECK = 3'b100
  } ctf_ref_state_type;
endpackage

// >>> src/ctf_temp_chan.sv
`timescale 1ns/1ps
module ctf_temp_chan (
  input wire logic mclk_i,
  input wire logic reg_rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [13:0] data_i,
  input wire logic test_en_i,
  input wire logic [13:0] limit_i,
  output logic [13:0] value_o,
  output logic fault_o
);
  logic [13:0] next_value;

  // ==========================================================
  // value register, kept whether or not the input is tested
  always_comb
  begin
    next_value = value_o;
    if (load_i)
    begin
      next_value = data_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reg_rst_i)
    begin
      value_o <= ctf_pkg::VALUE_RST;
    end
    else if (ce_i)
    begin
      value_o <= next_value;
    end
  end

  // ==========================================================
  // open and over-temperature detection share one fault event
  always_comb
  begin
    fault_o = load_i & test_en_i & // RULE11
      ((data_i > ctf_pkg::OPEN_THRESH) | // RULE8
      (data_i < limit_i)); // RULE9
  end
endmodule // ctf_temp_chan

// >>> src/ctf_core.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE1] mask bit hides cell fault, voltage still reported
// [RULE2] reference power-good check starts 20ms after start
// [RULE3] enable pin low resets device; pulled high
// [RULE4] hard reset command drops internal enable
// [RULE5] hard reset spares sleep-mode regulators
// [RULE6] hard and soft reset restore register defaults
// [RULE7] six inputs; pull-ups only while bias active
// [RULE8] above 31/32 full scale flags open input
// [RULE9] below limit flags over-temperature
// [RULE10] host reads value to tell open from hot
// [RULE11] test enable bit turns on fault checks
module ctf_core #(
  parameter int REF_DELAY = ctf_pkg::REF_DELAY_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic en_pin_i,
  input wire logic ref_good_pin_i,
  input wire logic hard_reset_command_i,
  input wire logic soft_reset_command_i,
  input wire logic wake_done_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [13:0] cell_open_raw_i,
  input wire logic [13:0] cell_uv_raw_i,
  input wire logic conv_valid_i,
  input wire logic [2:0] conv_chan_i,
  input wire logic [13:0] conv_data_i,
  output logic [15:0] rd_data_o,
  output logic [13:0] cell_open_o,
  output logic [13:0] cell_uv_o,
  output logic thermistor_bias_output_o,
  output logic [5:0] temp_pullup_en_o,
  output logic sleep_reg_on_o,
  output logic int_enable_o,
  output logic ref_fault_o,
  output logic overtemp_summary_flag_o
);
  // ==========================================================
  // pin synchronisers and internal reset
  logic en_meta;
  logic en_sync;
  logic ref_meta;
  logic ref_sync;
  logic hard_low;
  logic core_rst;
  logic reg_rst;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      en_meta <= 1'b1;
      en_sync <= 1'b1;
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      hard_low <= 1'b0;
      sleep_reg_on_o <= 1'b0;
    end
    else if (ce_i)
    begin
      en_meta <= en_pin_i;
      en_sync <= en_meta;
      ref_meta <= ref_good_pin_i;
      ref_sync <= ref_meta;
      hard_low <= hard_reset_command_i; // RULE4
      sleep_reg_on_o <= 1'b1; // RULE5
    end
  end

  // device reset from pin, hard command or power-on
  always_comb
  begin
    core_rst = !rst_b_i | !en_sync | hard_low; // RULE3 RULE4
    reg_rst = core_rst | soft_reset_command_i; // RULE6
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      int_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      int_enable_o <= en_sync & !hard_low & !hard_reset_command_i; // RULE4
    end
  end

  // ==========================================================
  // reference power-good check
  ctf_pkg::ctf_ref_state_type ref_state;
  ctf_pkg::ctf_ref_state_type next_ref_state;
  logic [22:0] ref_cnt;
  logic [22:0] next_ref_cnt;
  logic next_ref_fault;
  logic ref_fault_clr;

  always_comb
  begin
    next_ref_state = ref_state;
    next_ref_cnt = ref_cnt;
    next_ref_fault = ref_fault_o & !ref_fault_clr;
    case (ref_state)
      ctf_pkg::REF_IDLE:
      begin
        next_ref_cnt = '0;
      end
      ctf_pkg::REF_WAIT:
      begin
        if (ref_cnt >= 23'(REF_DELAY - 1))
        begin
          next_ref_state = ctf_pkg::REF_CHECK; // RULE2
        end
        else
        begin
          next_ref_cnt = ref_cnt + 23'h000001;
        end
      end
      ctf_pkg::REF_CHECK:
      begin
        if (!ref_sync)
        begin
          next_ref_fault = 1'b1; // RULE2
        end
      end
      default:
      begin
        next_ref_state = ctf_pkg::REF_IDLE;
      end
    endcase
    if (wake_done_i)
    begin
      next_ref_state = ctf_pkg::REF_WAIT; // RULE2
      next_ref_cnt = '0;
    end
  end

  // core reset lands in the wait state: covers power-up and enable rise
  always_ff @(posedge mclk_i)
  begin
    if (core_rst)
    begin
      ref_state <= ctf_pkg::REF_WAIT; // RULE2
      ref_cnt <= '0;
      ref_fault_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ref_state <= next_ref_state;
      ref_cnt <= next_ref_cnt;
      ref_fault_o <= next_ref_fault;
    end
  end

  // ==========================================================
  // registers
  logic [13:0] cell_fault_override_mask;
  logic [5:0] fault_setup;
  logic [13:0] temp_limit;
  logic [5:0] ot_fault;
  logic [5:0] next_ot_fault;
  logic ctrl_bias;
  logic [13:0] next_mask;
  logic [5:0] next_setup;
  logic [13:0] next_limit;
  logic next_bias;
  logic next_ot_flag;
  logic [15:0] next_rd_data;
  logic [5:0] temp_fault;
  logic [13:0] temp_value [6];
  logic [2:0] val_idx;

  always_comb
  begin
    next_mask = cell_fault_override_mask;
    next_setup = fault_setup;
    next_limit = temp_limit;
    next_bias = ctrl_bias;
    ref_fault_clr = 1'b0;
    next_ot_fault = ot_fault | temp_fault; // RULE8 RULE9
    next_ot_flag = overtemp_summary_flag_o | (|temp_fault); // RULE8
    if (wr_i)
    begin
      if (addr_i == ctf_pkg::OFS_CELL_MASK)
      begin
        next_mask = wr_data_i[13:0];
      end
      else if (addr_i == ctf_pkg::OFS_FAULT_SETUP)
      begin
        next_setup = wr_data_i[5:0];
      end
      else if (addr_i == ctf_pkg::OFS_TEMP_LIMIT)
      begin
        next_limit = wr_data_i[13:0];
      end
      else if (addr_i == ctf_pkg::OFS_OT_FAULT)
      begin
        next_ot_fault = (ot_fault & ~wr_data_i[5:0]) | temp_fault;
      end
      else if (addr_i == ctf_pkg::OFS_FAULT_STATUS)
      begin
        if (wr_data_i[ctf_pkg::STAT_OT_BIT])
        begin
          next_ot_flag = |temp_fault;
        end
        ref_fault_clr = wr_data_i[ctf_pkg::STAT_REF_BIT];
      end
      else if (addr_i == ctf_pkg::OFS_CONTROL)
      begin
        next_bias = wr_data_i[ctf_pkg::CTRL_BIAS_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reg_rst)
    begin
      cell_fault_override_mask <= ctf_pkg::CELL_MASK_RST; // RULE6
      fault_setup <= ctf_pkg::FAULT_SETUP_RST;
      temp_limit <= ctf_pkg::TEMP_LIMIT_RST;
      ctrl_bias <= 1'b0;
      ot_fault <= 6'h00;
      overtemp_summary_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cell_fault_override_mask <= next_mask;
      fault_setup <= next_setup;
      temp_limit <= next_limit;
      ctrl_bias <= next_bias;
      ot_fault <= next_ot_fault;
      overtemp_summary_flag_o <= next_ot_flag;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_comb
  begin
    val_idx = 3'(addr_i - ctf_pkg::OFS_VALUE_BASE);
    next_rd_data = 16'h0000;
    if (!rd_i)
    begin
      next_rd_data = 16'h0000;
    end
    else if (addr_i == ctf_pkg::OFS_CELL_MASK)
    begin
      next_rd_data = {2'h0, cell_fault_override_mask};
    end
    else if (addr_i == ctf_pkg::OFS_FAULT_SETUP)
    begin
      next_rd_data = {10'h000, fault_setup};
    end
    else if (addr_i == ctf_pkg::OFS_TEMP_LIMIT)
    begin
      next_rd_data = {2'h0, temp_limit};
    end
    else if (addr_i == ctf_pkg::OFS_OT_FAULT)
    begin
      next_rd_data = {10'h000, ot_fault};
    end
    else if (addr_i == ctf_pkg::OFS_FAULT_STATUS)
    begin
      next_rd_data = {12'h000, ref_state == ctf_pkg::REF_CHECK,
        (|cell_open_o) | (|cell_uv_o), ref_fault_o, overtemp_summary_flag_o};
    end
    else if (addr_i == ctf_pkg::OFS_CONTROL)
    begin
      next_rd_data = {15'h0000, ctrl_bias};
    end
    else if (addr_i >= ctf_pkg::OFS_VALUE_BASE && addr_i <= ctf_pkg::OFS_VALUE_LAST)
    begin
      next_rd_data = {2'h0, temp_value[val_idx]}; // RULE10
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reg_rst)
    begin
      rd_data_o <= 16'h0000;
    end
    else if (ce_i)
    begin
      rd_data_o <= next_rd_data;
    end
  end

  // ==========================================================
  // cell faults gated by override mask; voltage path untouched
  logic [13:0] next_cell_open;
  logic [13:0] next_cell_uv;

  always_comb
  begin
    next_cell_open = cell_open_raw_i & ~cell_fault_override_mask; // RULE1
    next_cell_uv = cell_uv_raw_i & ~cell_fault_override_mask; // RULE1
  end

  always_ff @(posedge mclk_i)
  begin
    if (reg_rst)
    begin
      cell_open_o <= 14'h0000;
      cell_uv_o <= 14'h0000;
    end
    else if (ce_i)
    begin
      cell_open_o <= next_cell_open;
      cell_uv_o <= next_cell_uv;
    end
  end

  // ==========================================================
  // thermistor bias and pull-up switches follow control bit
  always_ff @(posedge mclk_i)
  begin
    if (reg_rst)
    begin
      thermistor_bias_output_o <= 1'b0;
      temp_pullup_en_o <= 6'h00;
    end
    else if (ce_i)
    begin
      thermistor_bias_output_o <= next_bias;
      temp_pullup_en_o <= {6{next_bias}}; // RULE7
    end
  end

  // ==========================================================
  // six temperature channels: four external, two gpio
  genvar gi;
  generate
    for (gi = 0; gi < ctf_pkg::TEMP_N; gi++)
    begin : g_chan
      ctf_temp_chan u_chan (
        .mclk_i(mclk_i),
        .reg_rst_i(reg_rst),
        .ce_i(ce_i),
        .load_i(conv_valid_i && conv_chan_i == 3'(gi)), // RULE7
        .data_i(conv_data_i),
        .test_en_i(fault_setup[gi]), // RULE11
        .limit_i(temp_limit),
        .value_o(temp_value[gi]),
        .fault_o(temp_fault[gi])
      );
    end
  endgenerate
endmodule // ctf_core

// >>> tb/ctf_host_pins.sv
`timescale 1ns/1ps
// ==========================================================
// board side of the enable and reference pins
module ctf_host_pins (
  input wire logic pull_low_i,
  input wire logic ref_bad_i,
  output logic en_pin_o,
  output logic ref_good_o
);
  // pull-up holds the pin high unless someone pulls it low
  assign en_pin_o = !pull_low_i;
  // reference good unless the bench spoils it
  assign ref_good_o = !ref_bad_i;
endmodule // ctf_host_pins

// >>> tb/ctf_core_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checks
module ctf_checks (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic en_pin_i,
  input wire logic hard_reset_command_i,
  input wire logic soft_reset_command_i,
  input wire logic rd_i,
  input wire logic [13:0] cell_open_raw_i,
  input logic [15:0] rd_data_o,
  input logic [13:0] cell_open_o,
  input logic thermistor_bias_output_o,
  input logic [5:0] temp_pullup_en_o,
  input logic sleep_reg_on_o,
  input logic int_enable_o,
  input logic ref_fault_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // properties
  property p_mask;
    (cell_open_o & ~$past(cell_open_raw_i)) == 14'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("open flag without raw fault");
  property p_pull;
    temp_pullup_en_o == {6{thermistor_bias_output_o}};
  endproperty
  a_pull: assert property (p_pull) else $error("pull-ups differ from bias");
  property p_hard;
    hard_reset_command_i |=> !int_enable_o;
  endproperty
  a_hard: assert property (p_hard) else $error("enable kept after hard reset");
  property p_en;
    !en_pin_i [*4] |-> !int_enable_o;
  endproperty
  a_en: assert property (p_en) else $error("enable kept with pin low");
  property p_sleep;
    $past(rst_b_i) |-> sleep_reg_on_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep regulator dropped");
  property p_refwait;
    $rose(int_enable_o) |-> !ref_fault_o [*8];
  endproperty
  a_refwait: assert property (p_refwait) else $error("ref fault before delay");
  property p_rd;
    !$past(rd_i) |-> rd_data_o == 16'h0000;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_soft;
    soft_reset_command_i |=> ##1 cell_open_o == $past(cell_open_raw_i);
  endproperty
  a_soft: assert property (p_soft) else $error("mask kept after soft reset");
endmodule // ctf_checks

bind ctf_core ctf_checks chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .en_pin_i(en_pin_i),
  .hard_reset_command_i(hard_reset_command_i), .soft_reset_command_i(soft_reset_command_i),
  .rd_i(rd_i), .cell_open_raw_i(cell_open_raw_i), .rd_data_o(rd_data_o),
  .cell_open_o(cell_open_o), .thermistor_bias_output_o(thermistor_bias_output_o),
  .temp_pullup_en_o(temp_pullup_en_o), .sleep_reg_on_o(sleep_reg_on_o),
  .int_enable_o(int_enable_o), .ref_fault_o(ref_fault_o));

// >>> tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb;
  logic mclk_i, rst_b_i, ce_i, en_pin_i, ref_good_pin_i, hard_reset_command_i;
  logic soft_reset_command_i, wake_done_i, wr_i, rd_i, conv_valid_i, pull_low, ref_bad;
  logic [3:0] addr_i;
  logic [15:0] wr_data_i, rd_data_o;
  logic [13:0] cell_open_raw_i, cell_uv_raw_i, conv_data_i, cell_open_o, cell_uv_o;
  logic [2:0] conv_chan_i;
  logic [5:0] temp_pullup_en_o;
  logic thermistor_bias_output_o, sleep_reg_on_o, int_enable_o, ref_fault_o;
  logic overtemp_summary_flag_o;
  int fail_count, checked, cyc;
  // design and pins
  ctf_core #(.REF_DELAY(20)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .en_pin_i(en_pin_i), .ref_good_pin_i(ref_good_pin_i), .wake_done_i(wake_done_i),
    .hard_reset_command_i(hard_reset_command_i), .soft_reset_command_i(soft_reset_command_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .cell_open_raw_i(cell_open_raw_i), .cell_uv_raw_i(cell_uv_raw_i), .conv_valid_i(conv_valid_i),
    .conv_chan_i(conv_chan_i), .conv_data_i(conv_data_i), .cell_open_o(cell_open_o),
    .cell_uv_o(cell_uv_o), .thermistor_bias_output_o(thermistor_bias_output_o),
    .temp_pullup_en_o(temp_pullup_en_o), .sleep_reg_on_o(sleep_reg_on_o),
    .int_enable_o(int_enable_o), .ref_fault_o(ref_fault_o),
    .overtemp_summary_flag_o(overtemp_summary_flag_o));
  ctf_host_pins pins_u (.pull_low_i(pull_low), .ref_bad_i(ref_bad), .en_pin_o(en_pin_i),
    .ref_good_o(ref_good_pin_i));
  // ==========================================================
  // clock and hang guard
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      give_verdict;
    end
  end
  // ==========================================================
  // shared tasks
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 q = rd_data_o;
  endtask
  task cv(input logic [2:0] c, input logic [13:0] d);
    @(posedge mclk_i);
    conv_valid_i <= 1'b1;
    conv_chan_i <= c;
    conv_data_i <= d;
    @(posedge mclk_i);
    conv_valid_i <= 1'b0;
  endtask
  task pulse_soft;
    @(posedge mclk_i);
    soft_reset_command_i <= 1'b1;
    @(posedge mclk_i);
    soft_reset_command_i <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task t_mask;
    logic [15:0] q;
    wr(4'h0, 16'h0210);
    cell_open_raw_i <= 14'h3FFF;
    cell_uv_raw_i <= 14'h2AAA;
    tick(2);
    #1 chk(16'(cell_open_o), 16'h3DEF);
    chk(16'(cell_uv_o), 16'h28AA);
    rd(4'h0, q);
    chk(q, 16'h0210);
    rd(4'hE, q);
    chk(q, 16'h0000);
    $display("mask test done");
  endtask
  task t_temp;
    logic [15:0] q;
    wr(4'h1, 16'h000D);
    cell_open_raw_i <= 14'h0000;
    wr(4'h2, 16'h1000);
    cv(3'h0, 14'h3E01);
    cv(3'h1, 14'h3F00);
    cv(3'h2, 14'h0FFF);
    cv(3'h3, 14'h3E00);
    cv(3'h6, 14'h3FFF);
    rd(4'h3, q);
    chk(q, 16'h0005);
    rd(4'h4, q);
    chk(16'(q[0]), 16'h0001);
    chk(16'(q[2]), 16'h0001);
    rd(4'h8, q);
    chk(q, 16'h3E01);
    rd(4'h9, q);
    chk(q, 16'h3F00);
    chk(16'(overtemp_summary_flag_o), 16'h0001);
    wr(4'h3, 16'h003F);
    wr(4'h4, 16'h0001);
    rd(4'h3, q);
    chk(q, 16'h0000);
    chk(16'(overtemp_summary_flag_o), 16'h0000);
    $display("temperature test done");
  endtask
  task t_bias;
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(4'h5, 16'h0001);
    ce_i <= 1'b1;
    tick(1);
    #1 chk(16'(thermistor_bias_output_o), 16'h0000);
    wr(4'h5, 16'h0001);
    tick(1);
    #1 chk(16'(temp_pullup_en_o), 16'h003F);
    chk(16'(thermistor_bias_output_o), 16'h0001);
    wr(4'h5, 16'h0000);
    tick(1);
    #1 chk(16'(temp_pullup_en_o), 16'h0000);
    chk(16'(thermistor_bias_output_o), 16'h0000);
    $display("bias test done");
  endtask
  task t_soft;
    logic [15:0] q;
    wr(4'h0, 16'h1234);
    cell_open_raw_i <= 14'h3FFF;
    pulse_soft;
    rd(4'h0, q);
    chk(q, 16'h0000);
    chk(16'(cell_open_o), 16'h3FFF);
    $display("soft reset test done");
  endtask
  task t_ref;
    logic [15:0] q;
    @(posedge mclk_i);
    ref_bad <= 1'b1;
    wake_done_i <= 1'b1;
    @(posedge mclk_i);
    wake_done_i <= 1'b0;
    tick(10);
    #1 chk(16'(ref_fault_o), 16'h0000);
    tick(25);
    #1 chk(16'(ref_fault_o), 16'h0001);
    rd(4'h4, q);
    chk(16'(q[1]), 16'h0001);
    @(posedge mclk_i);
    ref_bad <= 1'b0;
    tick(4);
    wr(4'h4, 16'h0002);
    #1 chk(16'(ref_fault_o), 16'h0000);
    $display("reference test done");
  endtask
  task t_hard;
    logic [15:0] q;
    wr(4'h0, 16'h0001);
    @(posedge mclk_i);
    hard_reset_command_i <= 1'b1;
    @(posedge mclk_i);
    hard_reset_command_i <= 1'b0;
    #1 chk(16'(int_enable_o), 16'h0000);
    chk(16'(sleep_reg_on_o), 16'h0001);
    rd(4'h0, q);
    chk(q, 16'h0000);
    $display("hard reset test done");
  endtask
  task t_en;
    logic [15:0] q;
    wr(4'h0, 16'h0001);
    @(posedge mclk_i);
    pull_low <= 1'b1;
    tick(6);
    #1 chk(16'(int_enable_o), 16'h0000);
    @(posedge mclk_i);
    pull_low <= 1'b0;
    tick(4);
    rd(4'h0, q);
    chk(q, 16'h0000);
    chk(16'(int_enable_o), 16'h0001);
    rd(4'h4, q);
    chk(16'(q[3]), 16'h0000);
    tick(20);
    rd(4'h4, q);
    chk(16'(q[3]), 16'h0001);
    $display("enable pin test done");
  endtask
  // ==========================================================
  // verdict and main sequence
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    fail_count = 0;
    checked = 0;
    cyc = 0;
    {rst_b_i, hard_reset_command_i, soft_reset_command_i, wake_done_i, wr_i, rd_i} = 6'h00;
    {conv_valid_i, pull_low, ref_bad} = 3'h0;
    ce_i = 1'b1;
    addr_i = 4'h0;
    wr_data_i = 16'h0000;
    {cell_open_raw_i, cell_uv_raw_i, conv_data_i} = 42'h0;
    conv_chan_i = 3'h0;
    tick(2);
    rst_b_i <= 1'b1;
    t_mask;
    t_temp;
    t_bias;
    t_soft;
    t_ref;
    t_hard;
    t_en;
    give_verdict;
  end
endmodule // tb
